//--- core/rcrb_builder.sv
/*
 * Record chunk response builder: a response byte FIFO and the top module that turns
 * chunked record read requests into response fields, payload and checksum.
 * Assumes a record store that answers combinationally on the same clock, and a
 * requester that keeps its own side of the chunk protocol.
 */
// What this block does
// - Return 32-bit following record identifier.
// - Later chunks repeat first chunk's following id.
// - Record id fixed through one retrieval.
// - Zero following id when none follows.
// - Next chunk token, zero when nothing remains.
// - Zero token on first chunk means whole.
// - Position code first, middle, last, whole.
// - Byte count equals payload bytes sent.
// - Zero limit gives zero count, no payload.
// - Checksum appended only on last chunk.
`timescale 1ns/1ps
`default_nettype none
`include "rcrb_defs.svh"

// ==========================================================================
// Synchronous FIFO in flip-flops with valid and ready on both sides.
module rcrb_fifo #(
    parameter int WIDTH = `RCRB_FIFO_WIDTH,
    parameter int DEPTH = `RCRB_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    // Pointer width: one extra bit tells a full FIFO from an empty one.
    localparam int AW = $clog2(DEPTH);

    // Storage and pointers, each with its registered and its next value.
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic push, pop;

    // Full when pointers differ only in the wrap bit, empty when equal.
    assign in_ready = !((wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]));
    assign out_valid = (wptr_q != rptr_q);
    assign out_data = mem_q[rptr_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // A push and a pop may fall in one cycle; both pointers then move.
    // Next pointer and storage values.
    always_comb begin
        mem_d = mem_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        if (push) begin
            mem_d[wptr_q[AW-1:0]] = in_data;
            wptr_d = wptr_q + 1'b1;
        end
        if (pop) begin
            rptr_d = rptr_q + 1'b1;
        end
    end

    // Storage registers.
    always_ff @(posedge clock) begin
        mem_q <= mem_d;
    end

    // Pointer registers.
    always_ff @(posedge clock) begin
        if (rst) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
        end
    end
endmodule // rcrb_fifo

// ==========================================================================
// Response builder top.
module rcrb_builder (
    input wire logic clock,
    input wire logic rst,
    input wire rcrb_pkg::rcrb_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic [31:0] store_record_id,
    output logic [15:0] store_offset,
    input wire logic [15:0] store_length,
    input wire logic [31:0] store_following_id,
    input wire logic [7:0] store_byte,
    output rcrb_pkg::rcrb_byte_t out_byte,
    output logic out_valid,
    input wire logic out_ready,
    output logic busy
);
    // Checksum step over one byte, most significant bit first.
    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ `RCRB_CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // Picks byte n of the little-endian header.
    function automatic logic [7:0] hdr_byte(input logic [87:0] hdr, input logic [15:0] n);
        logic [7:0] b;
        b = 8'h00;
        for (int i = 0; i < 11; i++) begin
            if (n == 16'(i)) begin
                b = hdr[i*8 +: 8];
            end
        end
        return b;
    endfunction

    // Latched request: id, first chunk's following id, offset, count, header and checksum.
    rcrb_pkg::rcrb_state_t state_q, state_d;
    logic [31:0] rid_q, rid_d;
    logic [31:0] first_next_q, first_next_d;
    logic [15:0] off_q, off_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] idx_q, idx_d;
    logic [7:0] code_q, code_d;
    logic [7:0] crc_q, crc_d;
    logic [87:0] hdr_q, hdr_d;
    rcrb_pkg::rcrb_byte_t push_byte;
    logic push_valid, push_ready;
    logic take;
    logic first;
    logic [15:0] req_off, remain, count, left;
    logic [31:0] token, following;
    logic [7:0] code;

    // One request at a time: none is taken while a response is being built.
    assign req_ready = (state_q == rcrb_pkg::RCRB_IDLE);
    assign take = req_valid && req_ready;
    assign busy = !req_ready;
    // While idle the store is asked about the incoming record, otherwise the latched one.
    assign store_record_id = req_ready ? req.record_id : rid_q;
    assign store_offset = off_q;

    // Request decode: offset, byte count, token, position code and following id.
    always_comb begin
        first = (req.request_phase_flag == `RCRB_PHASE_FIRST);
        // A flag other than the first-chunk code is handled as a later chunk.
        // Later tokens carry the next offset plus one, so a later token is never zero.
        req_off = (first || req.chunk_token == `RCRB_TOKEN_NONE) ? 16'h0000 : 16'(req.chunk_token - 32'd1);
        remain = (req_off >= store_length) ? 16'h0000 : 16'(store_length - req_off);
        count = (req.requested_byte_limit < remain) ? req.requested_byte_limit : remain;
        left = 16'(remain - count);
        token = (left == 16'h0000) ? `RCRB_TOKEN_NONE : (32'(req_off) + 32'(count) + 32'd1);
        if (first) begin
            code = (left == 16'h0000) ? `RCRB_POS_WHOLE : `RCRB_POS_FIRST;
        end else begin
            code = (left == 16'h0000) ? `RCRB_POS_LAST : `RCRB_POS_MIDDLE;
        end
        following = first ? store_following_id : first_next_q;
    end

    // Sequencing of header, payload and checksum bytes into the FIFO.
    always_comb begin
        state_d = state_q;
        rid_d = rid_q;
        first_next_d = first_next_q;
        off_d = off_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        code_d = code_q;
        crc_d = crc_q;
        hdr_d = hdr_q;
        push_valid = 1'b0;
        push_byte = '0;
        unique case (state_q)
            rcrb_pkg::RCRB_IDLE: begin
                // Latch the request and its decoded header fields.
                if (take) begin
                    rid_d = req.record_id;
                    off_d = req_off;
                    cnt_d = count;
                    code_d = code;
                    idx_d = 16'h0000;
                    hdr_d = {count, code, token, following};
                    // A first chunk restarts the checksum and remembers its following id.
                    if (first) begin
                        first_next_d = store_following_id;
                        crc_d = `RCRB_CRC_INIT;
                    end
                    state_d = rcrb_pkg::RCRB_HDR;
                end
            end
            rcrb_pkg::RCRB_HDR: begin
                // Eleven header bytes, each field least significant byte first.
                push_valid = 1'b1;
                push_byte.data = hdr_byte(hdr_q, idx_q);
                push_byte.last = (idx_q == 16'(`RCRB_HDR_BYTES - 16'd1)) && (cnt_q == `RCRB_COUNT_NONE)
                    && (code_q != `RCRB_POS_LAST);
                if (push_ready) begin
                    idx_d = 16'(idx_q + 16'd1);
                    if (idx_q == 16'(`RCRB_HDR_BYTES - 16'd1)) begin
                        idx_d = 16'h0000;
                        if (cnt_q != `RCRB_COUNT_NONE) begin
                            state_d = rcrb_pkg::RCRB_PAY;
                        end else if (code_q == `RCRB_POS_LAST) begin
                            state_d = rcrb_pkg::RCRB_CRC;
                        end else begin
                            state_d = rcrb_pkg::RCRB_IDLE;
                        end
                    end
                end
            end
            rcrb_pkg::RCRB_PAY: begin
                // A stalled FIFO holds the offset, so the store offers the same byte again.
                push_valid = 1'b1;
                push_byte.data = store_byte;
                push_byte.last = (idx_q == 16'(cnt_q - 16'd1)) && (code_q != `RCRB_POS_LAST);
                if (push_ready) begin
                    crc_d = crc8_step(crc_q, store_byte);
                    off_d = 16'(off_q + 16'd1);
                    idx_d = 16'(idx_q + 16'd1);
                    if (idx_q == 16'(cnt_q - 16'd1)) begin
                        state_d = (code_q == `RCRB_POS_LAST) ? rcrb_pkg::RCRB_CRC : rcrb_pkg::RCRB_IDLE;
                    end
                end
            end
            rcrb_pkg::RCRB_CRC: begin
                // The checksum is right only when chunks are read in order, without retries.
                // checksum on last
                push_valid = 1'b1;
                push_byte.data = crc_q;
                push_byte.last = 1'b1;
                if (push_ready) begin
                    state_d = rcrb_pkg::RCRB_IDLE;
                end
            end
        endcase
    end

    // Reset leaves the builder idle, ready for a request at the next edge.
    // Sequencer registers.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= rcrb_pkg::RCRB_IDLE;
            rid_q <= `RCRB_ID_NONE;
            first_next_q <= `RCRB_ID_NONE;
            off_q <= 16'h0000;
            cnt_q <= `RCRB_COUNT_NONE;
            idx_q <= 16'h0000;
            code_q <= `RCRB_POS_FIRST;
            crc_q <= `RCRB_CRC_INIT;
            hdr_q <= '0;
        end else begin
            state_q <= state_d;
            rid_q <= rid_d;
            first_next_q <= first_next_d;
            off_q <= off_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            code_q <= code_d;
            crc_q <= crc_d;
            hdr_q <= hdr_d;
        end
    end

    // Response byte FIFO; a stalled drain stalls the sequencer.
    // Eight entries let a slow drain overlap the header build.
    rcrb_fifo #(
        .WIDTH(`RCRB_FIFO_WIDTH),
        .DEPTH(`RCRB_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_data(push_byte),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .out_data(out_byte),
        .out_valid(out_valid),
        .out_ready(out_ready)
    );
endmodule // rcrb_builder

`default_nettype wire

//--- core/rcrb_defs.svh
/*
 * Constants of the record chunk response builder: codes, field sizes and reset values.
 * Assumes it is included by bare name wherever one of these macros is used.
 */
`ifndef RCRB_DEFS_SVH
`define RCRB_DEFS_SVH

// ==========================================================================
// Request phase flag values.
`define RCRB_PHASE_LATER 8'h00
`define RCRB_PHASE_FIRST 8'h01

// ==========================================================================
// Chunk position codes.
`define RCRB_POS_FIRST 8'h00
`define RCRB_POS_MIDDLE 8'h01
`define RCRB_POS_LAST 8'h04
`define RCRB_POS_WHOLE 8'h05

// ==========================================================================
// Sizes and reset values.
`define RCRB_HDR_BYTES 16'h000B
`define RCRB_ID_NONE 32'h0000_0000
`define RCRB_TOKEN_NONE 32'h0000_0000
`define RCRB_COUNT_NONE 16'h0000
`define RCRB_CRC_POLY 8'h07
`define RCRB_CRC_INIT 8'h00
`define RCRB_FIFO_DEPTH 8
`define RCRB_FIFO_WIDTH 9

`endif

//--- core/rcrb_pkg.sv
/*
 * Types of the record chunk response builder.
 * Assumes nothing beyond a SystemVerilog compiler; constants live in rcrb_defs.svh.
 */
package rcrb_pkg;

    // ======================================================================
    // One read request as the requester issued it.
    typedef struct packed {
        logic [31:0] record_id;
        logic [31:0] chunk_token;
        logic [7:0] request_phase_flag;
        logic [15:0] requested_byte_limit;
    } rcrb_req_t;

    // ======================================================================
    // One byte of the response stream with its end marker.
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } rcrb_byte_t;

    // ======================================================================
    // Response emission states.
    typedef enum logic [1:0] {
        RCRB_IDLE = 2'b00,
        RCRB_HDR = 2'b01,
        RCRB_PAY = 2'b10,
        RCRB_CRC = 2'b11
    } rcrb_state_t;

endpackage

//--- bench/rcrb_builder_asserts.sv
/* Port checker of the response builder top.
   Assumes it is bound to rcrb_builder from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Response builder port checker.
module rcrb_builder_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire rcrb_pkg::rcrb_req_t req,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [31:0] store_record_id,
    input wire logic [31:0] store_following_id,
    input wire rcrb_pkg::rcrb_byte_t out_byte,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic busy
);
    // All checks share the one clock and its reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_hdr_busy: assert property (req_valid && req_ready |=> busy [*8])
        else $error("Builder idle before the header was built.");
    a_take_busy: assert property (req_valid && req_ready |=> busy)
        else $error("Taken request left the builder idle.");
    a_first_byte: assert property (req_valid && req_ready |-> ##2 out_valid)
        else $error("No response byte two cycles after the take.");
    a_first_field: assert property (req_valid && req_ready && !out_valid |-> ##2 out_valid &&
        out_byte.data == $past(store_following_id[7:0], 2) && !out_byte.last)
        else $error("Response does not open with the following id.");
    a_id_latched: assert property (req_valid && req_ready |=> store_record_id == $past(req.record_id))
        else $error("Latched record id is not the taken request id.");
    a_id_held: assert property (busy && $past(busy) |-> $stable(store_record_id))
        else $error("Record id moved during a response.");
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_byte))
        else $error("Stalled output byte changed.");
    a_end_queued: assert property ($fell(busy) |-> out_valid)
        else $error("Builder went idle with nothing queued.");
    // Main scenarios seen.
    c_take: cover property (req_valid && req_ready);
    c_last: cover property (out_valid && out_ready && out_byte.last);
    c_stall: cover property (out_valid && !out_ready && busy);
endmodule // rcrb_builder_asserts
`default_nettype wire

//--- bench/rcrb_store_model.sv
/* Record store model: three chained records.
   Assumes the builder reads it combinationally. */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Record store.
module rcrb_store_model (
    input wire logic [31:0] store_record_id,
    input wire logic [15:0] store_offset,
    output logic [15:0] store_length,
    output logic [31:0] store_following_id,
    output logic [7:0] store_byte
);
    logic [7:0] pat;
    // Records 1, 2 and 3 hold 5, 20 and 3 bytes; others are empty.
    assign store_length = (store_record_id == 32'h1) ? 16'h5 : (store_record_id == 32'h2) ? 16'h14 :
        (store_record_id == 32'h3) ? 16'h3 : 16'h0;
    assign store_following_id = (store_record_id == 32'h1 || store_record_id == 32'h2) ?
        store_record_id + 32'h1 : 32'h0;
    // Bytes past the end are inverted so a stray read shows.
    assign pat = store_offset[7:0] ^ {store_record_id[3:0], 4'hA};
    assign store_byte = (store_offset < store_length) ? pat : ~pat;
endmodule // rcrb_store_model
`default_nettype wire

//--- bench/tb_top.sv
/* Self-checking bench of the response builder.
   Assumes the store model and the port checker. */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench top.
module tb_top;
    logic clock, rst, req_valid, out_ready, req_ready, busy, out_valid;
    rcrb_pkg::rcrb_req_t req;
    rcrb_pkg::rcrb_byte_t out_byte;
    logic [31:0] store_record_id, store_following_id;
    logic [15:0] store_offset, store_length;
    logic [7:0] store_byte, crc_q;
    logic [7:0] got[$];
    int miscompares = 0;
    int tests_run = 0;
    // Clock of 25 ns.
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    rcrb_builder i_rcrb_builder (.clock(clock), .rst(rst), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .store_record_id(store_record_id), .store_offset(store_offset),
        .store_length(store_length), .store_following_id(store_following_id), .store_byte(store_byte),
        .out_byte(out_byte), .out_valid(out_valid), .out_ready(out_ready), .busy(busy));
    rcrb_store_model i_rcrb_store_model (.store_record_id(store_record_id), .store_offset(store_offset),
        .store_length(store_length), .store_following_id(store_following_id), .store_byte(store_byte));
    // Counts and reports one comparison.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d.", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Expected store byte and one checksum step, MSB first.
    function automatic logic [7:0] exp_byte(input logic [31:0] rid, input logic [15:0] off);
        return off[7:0] ^ {rid[3:0], 4'hA};
    endfunction
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        c = c ^ b;
        for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        return c;
    endfunction
    // Issues one request and gathers its response; stall halves the drain rate.
    task automatic xfer(input logic [31:0] rid, input logic [31:0] tok, input logic [7:0] flag,
        input logic [15:0] lim, input bit stall);
        int n;
        got = {};
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clock);
        if (n == 100) begin
            miscompares++;
            wrap_up();
        end
        req = '{rid, tok, flag, lim};
        req_valid = 1'b1;
        @(negedge clock);
        req_valid = 1'b0;
        for (n = 0; n < 400; n++) begin
            out_ready = !(stall && n[0]);
            if (out_valid === 1'b1 && out_ready) got.push_back(out_byte.data);
            if (out_valid === 1'b1 && out_ready && out_byte.last === 1'b1) break;
            @(negedge clock);
        end
        if (n == 400) begin
            miscompares++;
            wrap_up();
        end
    endtask
    // Compares the gathered response with fields worked out here.
    task automatic judge(input string nm, input logic [31:0] rid, input logic [31:0] fol,
        input logic [31:0] tok, input logic [7:0] code, input logic [15:0] cnt, input logic [15:0] off,
        input bit crc_on);
        logic [7:0] e;
        check({nm, " size"}, 32'(got.size()), {16'h0, cnt} + 32'hB + 32'(crc_on));
        check({nm, " following id"}, {got[3], got[2], got[1], got[0]}, fol);
        check({nm, " token"}, {got[7], got[6], got[5], got[4]}, tok);
        check({nm, " code"}, {24'h0, got[8]}, {24'h0, code});
        check({nm, " count"}, {16'h0, got[10], got[9]}, {16'h0, cnt});
        for (int i = 0; i < cnt; i++) begin
            e = exp_byte(rid, off + 16'(i));
            crc_q = crc8(crc_q, e);
            check({nm, " payload"}, {24'h0, got[11 + i]}, {24'h0, e});
        end
        if (crc_on) check({nm, " checksum"}, {24'h0, got[11 + cnt]}, {24'h0, crc_q});
        $display("Test %s done.", nm);
    endtask
    // Short record read whole, with the limit well above its length.
    task automatic t_whole();
        xfer(32'h1, 32'h0, 8'h01, 16'h10, 1'b0);
        judge("whole", 32'h1, 32'h2, 32'h0, 8'h05, 16'h5, 16'h0, 1'b0);
    endtask
    // Last record of the chain, limit equal to its length.
    task automatic t_tail();
        xfer(32'h3, 32'h0, 8'h01, 16'h3, 1'b0);
        judge("tail", 32'h3, 32'h0, 32'h0, 8'h05, 16'h3, 16'h0, 1'b0);
    endtask
    // Three chunks back to back, the middle one drained slowly.
    task automatic t_multi();
        crc_q = 8'h00;
        xfer(32'h2, 32'h0, 8'h01, 16'h8, 1'b0);
        judge("first", 32'h2, 32'h3, 32'h9, 8'h00, 16'h8, 16'h0, 1'b0);
        xfer(32'h2, 32'h9, 8'h00, 16'h8, 1'b1);
        judge("middle", 32'h2, 32'h3, 32'h11, 8'h01, 16'h8, 16'h8, 1'b0);
        xfer(32'h2, 32'h11, 8'h00, 16'h8, 1'b0);
        judge("last", 32'h2, 32'h3, 32'h0, 8'h04, 16'h4, 16'h10, 1'b1);
    endtask
    // A zero limit returns no payload.
    task automatic t_zero();
        xfer(32'h1, 32'h0, 8'h01, 16'h0, 1'b0);
        judge("zero", 32'h1, 32'h2, 32'h1, 8'h00, 16'h0, 16'h0, 1'b0);
    endtask
    // Reset for four cycles, then the scenarios.
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        out_ready = 1'b1;
        req = '0;
        crc_q = 8'h00;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        t_whole();
        t_tail();
        t_multi();
        t_zero();
        wrap_up();
    end
endmodule // tb_top
bind rcrb_builder rcrb_builder_asserts i_rcrb_builder_asserts (.clock(clock), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .store_record_id(store_record_id),
    .store_following_id(store_following_id), .out_byte(out_byte), .out_valid(out_valid),
    .out_ready(out_ready), .busy(busy));
`default_nettype wire
